// >>> common/tls_pkg.sv
// constants, codes and register map of the torque limit selector
// assumes one 200 MHz clock; frequencies in 0.01 Hz, torques in percent
// Operation
// - limit only under the three vector methods
// - code 05 refused for second motor
// - mode codes 00..04 decode to five modes
// - quadrant mode: limits one..four per quadrant
// - switch inputs pick limit one..four
// - analog 0..10 V maps to 0..200 percent
// - option modes only with board fitted
// - gate input off applies maximum torque
// - no gate input assigned: always limiting
// - limits scaled to 200 percent maximum torque
// - limit-active terminal on while limiting
// - no limiting below about three hertz
// - reverse block forbids counter-rotation frequency
// - ramp hold pauses ramp while limiting
package tls_pkg;
   localparam int          ADDR_W        = 5;
   localparam int          DATA_W        = 16;
   localparam int          N_IN          = 8;
   localparam int          N_OUT         = 5;
   localparam int          ADC_W         = 10;
   // register word addresses
   localparam logic [4:0]  A_METHOD      = 5'h00;
   localparam logic [4:0]  A_MODE        = 5'h01;
   localparam logic [4:0]  A_LIMIT1      = 5'h02;
   localparam logic [4:0]  A_CFG         = 5'h06;
   localparam logic [4:0]  A_STATUS      = 5'h07;
   localparam logic [4:0]  A_IN_FUNC     = 5'h08;
   localparam logic [4:0]  A_OUT_FUNC    = 5'h10;
   // field positions
   localparam int          F_METH2       = 4;
   localparam int          F_RAMP_EN     = 0;
   localparam int          F_REV_EN      = 1;
   // reset values
   localparam logic [2:0]  RST_METHOD    = 3'h0;
   localparam logic [2:0]  RST_MODE      = 3'h0;
   localparam logic [7:0]  RST_LIMIT     = 8'hB4;
   localparam logic [7:0]  RST_FUNC      = 8'hFF;
   // method codes
   localparam logic [2:0]  METH_SLV      = 3'h3;
   localparam logic [2:0]  METH_SLV0     = 3'h4;
   localparam logic [2:0]  METH_VS       = 3'h5;
   // terminal function codes (decimal 40, 41, 42, 10)
   localparam logic [7:0]  FN_GATE       = 8'h28;
   localparam logic [7:0]  FN_SW_A       = 8'h29;
   localparam logic [7:0]  FN_SW_B       = 8'h2A;
   localparam logic [7:0]  FN_ACTIVE     = 8'h0A;
   // scaling and thresholds
   localparam logic [7:0]  LIMIT_MAX     = 8'hB4;
   localparam logic [7:0]  TRQ_MAX       = 8'hC8;
   localparam logic [9:0]  ADC_FULL      = 10'h3FF;
   localparam logic [15:0] FREQ_MIN      = 16'h012C;
   typedef enum logic [2:0] {
      TLS_QUAD, TLS_TERM, TLS_ANALOG, TLS_OPT1, TLS_OPT2, TLS_NONE
   } tls_mode_t;
   typedef enum logic [1:0] {
      TLS_FWD_PWR, TLS_REV_REG, TLS_REV_PWR, TLS_FWD_REG
   } tls_quad_t;
endpackage

// >>> common/tls_quad_if.sv
// carries frequency and torque samples to the quadrant classifier
// assumes both ends on the block's single clock
interface tls_quad_if;
   logic signed [15:0]  freq;
   logic signed [15:0]  torque;
   tls_pkg::tls_quad_t  quad;
   modport src (output freq, output torque, input quad);
   modport cls (input freq, input torque, output quad);
endinterface

// >>> src/tls_sync.sv
// two-flop synchroniser for pins from outside the clock domain
// assumes inputs are quasi-static compared with the clock
module tls_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,     // control clock
   input  wire logic         reset_n, // sync reset, low
   input  wire logic [W-1:0] d,       // asynchronous input
   output logic      [W-1:0] q        // synchronised output
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // tls_sync

// >>> src/tls_quad.sv
// classifies the operating quadrant each clock
// assumes signed frequency and torque from the same clock domain
module tls_quad (
   input  wire logic clk,     // control clock
   input  wire logic reset_n, // sync reset, low
   tls_quad_if.cls   qi       // samples in, quadrant out
);
   wire rev = qi.freq[15];
   wire neg = qi.torque[15];
   tls_pkg::tls_quad_t quad_nxt;

   always_comb
   begin
      case ({rev, neg})
         2'b00:   quad_nxt = tls_pkg::TLS_FWD_PWR;
         2'b10:   quad_nxt = tls_pkg::TLS_REV_REG;
         2'b11:   quad_nxt = tls_pkg::TLS_REV_PWR;
         default: quad_nxt = tls_pkg::TLS_FWD_REG;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         qi.quad <= tls_pkg::TLS_FWD_PWR;
      else
         qi.quad <= quad_nxt;
   end
endmodule // tls_quad

// >>> src/tls_top.sv
// torque limit selector: picks and applies the motor torque limit
// assumes register port on CLK; pins and ADC sample arrive asynchronously
//
// Implementation choices: the plain strobed port and the placing of the registers.
module tls_top (
   input  wire logic               CLK,        // 200 MHz control clock
   input  wire logic               RESET_N,    // sync reset, low
   input  wire logic [4:0]         ADDR,       // register word address
   input  wire logic [15:0]        WDATA,      // write data
   input  wire logic               WR,         // write strobe
   input  wire logic               RD,         // read strobe
   output logic      [15:0]        RDATA,      // read data, cycle after RD
   input  wire logic [7:0]         IN_TERM,    // input terminals, high on
   input  wire logic [9:0]         AUX_ADC,    // aux analog sample
   input  wire logic               MOTOR2,     // second motor selected
   input  wire logic               OPT1_FIT,   // option board one fitted
   input  wire logic               OPT2_FIT,   // option board two fitted
   input  wire logic [7:0]         OPT_LIMIT,  // limit from option board
   input  wire logic signed [15:0] FREQ_IN,    // ramp output, 0.01 Hz
   input  wire logic signed [15:0] TORQUE_IN,  // estimated torque, percent
   input  wire logic               RUN_REV,    // run command reverse
   output logic      [7:0]         TRQ_LIMIT,  // applied limit, percent
   output logic                    RAMP_HOLD,  // hold ramp generator
   output logic                    LIMIT_ACT,  // limiting operating
   output logic signed [15:0]      FREQ_OUT,   // frequency to power stage
   output logic      [4:0]         OUT_TERM    // output terminals
);
   // ---- register file ----
   logic [2:0] meth1_r;
   logic [2:0] meth2_r;
   logic [2:0] mode_sel_r;
   logic [7:0] limit_r    [4];
   logic       ramp_en_r;
   logic       rev_en_r;
   logic [7:0] in_func_r  [tls_pkg::N_IN];
   logic [7:0] out_func_r [tls_pkg::N_OUT];
   logic [2:0] mode_r;

   wire [7:0] wr_lim = (WDATA[7:0] > tls_pkg::LIMIT_MAX) ?
                       tls_pkg::LIMIT_MAX : WDATA[7:0];
   wire [2:0] wr_m1  = WDATA[2:0];
   wire [2:0] wr_m2  = WDATA[tls_pkg::F_METH2 +: 3];
   wire       wr_meth = WR && (ADDR == tls_pkg::A_METHOD);
   wire       m2_ok  = (wr_m2 != tls_pkg::METH_VS);

   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         meth1_r    <= tls_pkg::RST_METHOD;
         meth2_r    <= tls_pkg::RST_METHOD;
         mode_sel_r <= tls_pkg::RST_MODE;
         ramp_en_r  <= 1'b0;
         rev_en_r   <= 1'b0;
      end
      else
      begin
         if (wr_meth)
            meth1_r <= wr_m1;
         if (wr_meth && m2_ok)
            meth2_r <= wr_m2;
         if (WR && ADDR == tls_pkg::A_MODE)
            mode_sel_r <= WDATA[2:0];
         if (WR && ADDR == tls_pkg::A_CFG)
         begin
            ramp_en_r <= WDATA[tls_pkg::F_RAMP_EN];
            rev_en_r  <= WDATA[tls_pkg::F_REV_EN];
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_lim
         always_ff @(posedge CLK)
         begin
            if (!RESET_N)
               limit_r[gi] <= tls_pkg::RST_LIMIT;
            else if (WR && ADDR == tls_pkg::A_LIMIT1 + 5'(gi))
               limit_r[gi] <= wr_lim;
         end
      end
      for (gi = 0; gi < tls_pkg::N_IN; gi++)
      begin : g_inf
         always_ff @(posedge CLK)
         begin
            if (!RESET_N)
               in_func_r[gi] <= tls_pkg::RST_FUNC;
            else if (WR && ADDR == tls_pkg::A_IN_FUNC + 5'(gi))
               in_func_r[gi] <= WDATA[7:0];
         end
      end
      for (gi = 0; gi < tls_pkg::N_OUT; gi++)
      begin : g_outf
         always_ff @(posedge CLK)
         begin
            if (!RESET_N)
               out_func_r[gi] <= tls_pkg::RST_FUNC;
            else if (WR && ADDR == tls_pkg::A_OUT_FUNC + 5'(gi))
               out_func_r[gi] <= WDATA[7:0];
         end
      end
   endgenerate

   // ---- pin synchronisers ----
   logic [7:0] term_s;
   logic [9:0] adc_s;
   logic [7:0] opt_lim_s;
   logic [2:0] misc_s;

   tls_sync #(.W(8)) u_sync_term (
      .clk     (CLK),
      .reset_n (RESET_N),
      .d       (IN_TERM),
      .q       (term_s)
   );
   tls_sync #(.W(10)) u_sync_adc (
      .clk     (CLK),
      .reset_n (RESET_N),
      .d       (AUX_ADC),
      .q       (adc_s)
   );
   tls_sync #(.W(8)) u_sync_opt (
      .clk     (CLK),
      .reset_n (RESET_N),
      .d       (OPT_LIMIT),
      .q       (opt_lim_s)
   );
   tls_sync #(.W(3)) u_sync_misc (
      .clk     (CLK),
      .reset_n (RESET_N),
      .d       ({MOTOR2, OPT2_FIT, OPT1_FIT}),
      .q       (misc_s)
   );

   // ---- quadrant classifier ----
   tls_quad_if qbus ();
   assign qbus.freq   = FREQ_IN;
   assign qbus.torque = TORQUE_IN;

   tls_quad u_quad (
      .clk     (CLK),
      .reset_n (RESET_N),
      .qi      (qbus.cls)
   );

   // ---- terminal decoding ----
   // any terminal carrying a function code
   function automatic logic fn_assigned(input logic [7:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < tls_pkg::N_IN; i++)
         hit = hit | (in_func_r[i] == code);
      return hit;
   endfunction

   // any terminal carrying the code and on
   function automatic logic fn_on(input logic [7:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < tls_pkg::N_IN; i++)
         hit = hit | ((in_func_r[i] == code) & term_s[i]);
      return hit;
   endfunction

   function automatic logic is_vector(input logic [2:0] m,
                                      input logic       allow_vs);
      return (m == tls_pkg::METH_SLV) || (m == tls_pkg::METH_SLV0) ||
             (allow_vs && m == tls_pkg::METH_VS);
   endfunction

   logic gate_assigned;
   logic gate_on;
   logic sw_a;
   logic sw_b;
   wire  motor2 = misc_s[2];

   // the functions read the terminal tables directly: a process
   // follows those tables, a plain assign would only follow the code
   always_comb
   begin
      gate_assigned = fn_assigned(tls_pkg::FN_GATE);
      gate_on       = fn_on(tls_pkg::FN_GATE);
      sw_a          = fn_on(tls_pkg::FN_SW_A);
      sw_b          = fn_on(tls_pkg::FN_SW_B);
   end

   // ---- registered selections ----
   logic       vector_r;
   logic       gate_r;
   logic [1:0] sw_r;

   wire vector_nxt = motor2 ? is_vector(meth2_r, 1'b0)
                            : is_vector(meth1_r, 1'b1);
   wire gate_nxt   = !gate_assigned || gate_on;

   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         vector_r <= 1'b0;
         gate_r   <= 1'b0;
         sw_r     <= 2'h0;
         mode_r   <= tls_pkg::RST_MODE;
      end
      else
      begin
         vector_r <= vector_nxt;
         gate_r   <= gate_nxt;
         sw_r     <= {sw_b, sw_a};
         mode_r   <= mode_sel_r;
      end
   end

   // ---- mode decode ----
   tls_pkg::tls_mode_t mode_dec;

   always_comb
   begin
      case (mode_r)
         3'h0:    mode_dec = tls_pkg::TLS_QUAD;
         3'h1:    mode_dec = tls_pkg::TLS_TERM;
         3'h2:    mode_dec = tls_pkg::TLS_ANALOG;
         3'h3:    mode_dec = tls_pkg::TLS_OPT1;
         3'h4:    mode_dec = tls_pkg::TLS_OPT2;
         default: mode_dec = tls_pkg::TLS_NONE;
      endcase
   end

   // analog 0..full scale to 0..200 percent, linear
   wire [17:0] adc_prod  = 18'(adc_s) * 18'(tls_pkg::TRQ_MAX);
   wire [17:0] adc_div   = adc_prod / 18'(tls_pkg::ADC_FULL);
   wire [7:0]  adc_limit = adc_div[7:0];

   wire [7:0] quad_limit = limit_r[qbus.quad];
   wire [7:0] term_limit = limit_r[sw_r];

   logic [7:0] mode_limit;
   logic       mode_valid;

   always_comb
   begin
      mode_limit = tls_pkg::TRQ_MAX;
      mode_valid = 1'b1;
      case (mode_dec)
         tls_pkg::TLS_QUAD:   mode_limit = quad_limit;
         tls_pkg::TLS_TERM:   mode_limit = term_limit;
         tls_pkg::TLS_ANALOG: mode_limit = adc_limit;
         tls_pkg::TLS_OPT1:   mode_valid = misc_s[0];
         tls_pkg::TLS_OPT2:   mode_valid = misc_s[1];
         default:             mode_valid = 1'b0;
      endcase
      if ((mode_dec == tls_pkg::TLS_OPT1 || mode_dec == tls_pkg::TLS_OPT2)
          && mode_valid)
         mode_limit = opt_lim_s;
   end

   // ---- application ----
   wire [15:0] freq_abs  = FREQ_IN[15] ? 16'(-FREQ_IN) : 16'(FREQ_IN);
   wire [15:0] trq_abs   = TORQUE_IN[15] ? 16'(-TORQUE_IN) : 16'(TORQUE_IN);
   wire        freq_ok   = freq_abs >= tls_pkg::FREQ_MIN;
   wire        in_force  = vector_r && gate_r && mode_valid && freq_ok;
   // limit on the 200 percent = max torque scale
   wire [7:0]  lim_nxt   = in_force ? mode_limit : tls_pkg::TRQ_MAX;
   wire        act_nxt   = in_force && (trq_abs >= {8'h00, mode_limit});
   wire        hold_nxt  = ramp_en_r && vector_r && act_nxt;
   wire        wrong_dir = (FREQ_IN != 16'sh0000) && (FREQ_IN[15] != RUN_REV);
   wire        block     = rev_en_r && vector_r && wrong_dir;
   wire [15:0] fout_nxt  = block ? 16'h0000 : 16'(FREQ_IN);

   logic [4:0] term_nxt;
   always_comb
   begin
      for (int j = 0; j < tls_pkg::N_OUT; j++)
         term_nxt[j] = (out_func_r[j] == tls_pkg::FN_ACTIVE) && act_nxt;
   end

   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         TRQ_LIMIT <= tls_pkg::TRQ_MAX;
         LIMIT_ACT <= 1'b0;
         RAMP_HOLD <= 1'b0;
         FREQ_OUT  <= 16'sh0000;
         OUT_TERM  <= 5'h00;
      end
      else
      begin
         TRQ_LIMIT <= lim_nxt;
         LIMIT_ACT <= act_nxt;
         RAMP_HOLD <= hold_nxt;
         FREQ_OUT  <= fout_nxt;
         OUT_TERM  <= term_nxt;
      end
   end

   // ---- read port ----
   wire [4:0]  in_idx  = ADDR - tls_pkg::A_IN_FUNC;
   wire [4:0]  out_idx = ADDR - tls_pkg::A_OUT_FUNC;
   wire [4:0]  lim_idx = ADDR - tls_pkg::A_LIMIT1;
   wire [15:0] status  = {3'h0, RAMP_HOLD, vector_r, LIMIT_ACT,
                          qbus.quad, TRQ_LIMIT};
   logic [15:0] rd_nxt;

   always_comb
   begin
      rd_nxt = 16'h0000;
      if (ADDR == tls_pkg::A_METHOD)
         rd_nxt = {9'h000, meth2_r, 1'b0, meth1_r};
      else if (ADDR == tls_pkg::A_MODE)
         rd_nxt = {13'h0000, mode_sel_r};
      else if (ADDR >= tls_pkg::A_LIMIT1 && ADDR < tls_pkg::A_CFG)
         rd_nxt = {8'h00, limit_r[lim_idx[1:0]]};
      else if (ADDR == tls_pkg::A_CFG)
         rd_nxt = {14'h0000, rev_en_r, ramp_en_r};
      else if (ADDR == tls_pkg::A_STATUS)
         rd_nxt = status;
      else if (ADDR >= tls_pkg::A_IN_FUNC && ADDR < tls_pkg::A_OUT_FUNC)
         rd_nxt = {8'h00, in_func_r[in_idx[2:0]]};
      else if (ADDR >= tls_pkg::A_OUT_FUNC &&
               ADDR < tls_pkg::A_OUT_FUNC + 5'(tls_pkg::N_OUT))
         rd_nxt = {8'h00, out_func_r[out_idx[2:0]]};
   end

   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
         RDATA <= 16'h0000;
      else if (RD)
         RDATA <= rd_nxt;
      else
         RDATA <= 16'h0000;
   end
endmodule // tls_top

// >>> test/tls_top_checker.sv
// assertions on the torque limit selector's ports
// assumes binding to tls_top on its single clock
module tls_top_checker (
   input wire logic               CLK,       // clock
   input wire logic               RESET_N,   // reset, low
   input wire logic               WR,        // write strobe
   input wire logic               RD,        // read strobe
   input wire logic        [15:0] RDATA,     // read data
   input wire logic        [7:0]  IN_TERM,   // input pins
   input wire logic        [9:0]  AUX_ADC,   // analog sample
   input wire logic               MOTOR2,    // motor two
   input wire logic               OPT1_FIT,  // board one
   input wire logic               OPT2_FIT,  // board two
   input wire logic        [7:0]  OPT_LIMIT, // board limit
   input wire logic signed [15:0] FREQ_IN,   // frequency in
   input wire logic signed [15:0] TORQUE_IN, // torque in
   input wire logic               RUN_REV,   // reverse run
   input wire logic        [7:0]  TRQ_LIMIT, // applied limit
   input wire logic               RAMP_HOLD, // ramp hold
   input wire logic               LIMIT_ACT, // limiting
   input wire logic signed [15:0] FREQ_OUT,  // frequency out
   input wire logic        [4:0]  OUT_TERM   // output pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0]  quiet_r;
   logic [15:0] abs_t;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);
   assign abs_t = TORQUE_IN < 0 ? 16'(-TORQUE_IN) : 16'(TORQUE_IN);
   // cycles with every limit input unchanged
   always_ff @(posedge CLK)
      if (!RESET_N || WR || !$stable({IN_TERM, AUX_ADC, MOTOR2, OPT1_FIT, OPT2_FIT, OPT_LIMIT})
          || !$stable({FREQ_IN, TORQUE_IN}))
         quiet_r <= 3'h0;
      else if (quiet_r != 3'h7)
         quiet_r <= quiet_r + 3'h1;
   property p_low_freq;
      (FREQ_IN > -16'sh012C && FREQ_IN < 16'sh012C) [*3] |=> TRQ_LIMIT == 8'hC8 && !LIMIT_ACT;
   endproperty
   a_low_freq: assert property (p_low_freq) else $error("limit at low frequency");
   property p_term_act;
      |OUT_TERM |-> LIMIT_ACT;
   endproperty
   a_term_act: assert property (p_term_act) else $error("terminal without limiting");
   property p_hold_act;
      RAMP_HOLD |-> LIMIT_ACT;
   endproperty
   a_hold_act: assert property (p_hold_act) else $error("ramp held without limiting");
   property p_freq_pass;
      FREQ_OUT != 16'sh0000 |-> FREQ_OUT == $past(FREQ_IN);
   endproperty
   a_freq_pass: assert property (p_freq_pass) else $error("frequency altered");
   property p_freq_block;
      $past(RESET_N) && FREQ_OUT == 16'sh0000 && $past(FREQ_IN) != 16'sh0000
         |-> ($past(FREQ_IN) < 0) != $past(RUN_REV);
   endproperty
   a_freq_block: assert property (p_freq_block) else $error("forward frequency blocked");
   property p_max_scale;
      TRQ_LIMIT <= 8'hC8;
   endproperty
   a_max_scale: assert property (p_max_scale) else $error("limit above full scale");
   property p_act_torque;
      quiet_r == 3'h7 && LIMIT_ACT |-> abs_t >= {8'h00, TRQ_LIMIT};
   endproperty
   a_act_torque: assert property (p_act_torque) else $error("active below limit");
   property p_settled;
      quiet_r == 3'h7 |-> $stable(TRQ_LIMIT) && $stable(LIMIT_ACT);
   endproperty
   a_settled: assert property (p_settled) else $error("limit moved with inputs still");
   property p_reset_max;
      disable iff (1'b0) !RESET_N |=> TRQ_LIMIT == 8'hC8 && !LIMIT_ACT && RDATA == 16'h0000;
   endproperty
   a_reset_max: assert property (p_reset_max) else $error("reset state wrong");
   property p_rdata_idle;
      !$past(RD) |-> RDATA == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data out of slot");
   c_act: cover property (LIMIT_ACT && RAMP_HOLD);
   c_block: cover property (FREQ_OUT == 16'sh0000 && FREQ_IN != 16'sh0000);
   c_quiet: cover property (quiet_r == 3'h7 && TRQ_LIMIT != 8'hC8);
endmodule // tls_top_checker

bind tls_top tls_top_checker u_chk (
   .CLK, .RESET_N, .WR, .RD, .RDATA, .IN_TERM, .AUX_ADC, .MOTOR2, .OPT1_FIT, .OPT2_FIT,
   .OPT_LIMIT, .FREQ_IN, .TORQUE_IN, .RUN_REV, .TRQ_LIMIT, .RAMP_HOLD, .LIMIT_ACT,
   .FREQ_OUT, .OUT_TERM
);

// >>> test/tls_stage_model.sv
// power stage and run command as seen by the limit selector
// assumes the bench supplies commanded frequency and torque
module tls_stage_model (
   input wire logic               clk,       // control clock
   input wire logic               slow,      // update every fourth cycle
   input wire logic signed [15:0] freq_cmd,  // commanded frequency
   input wire logic signed [15:0] trq_cmd,   // commanded torque
   input wire logic               rev_cmd,   // reverse run wanted
   output logic signed     [15:0] freq_in,   // ramp output frequency
   output logic signed     [15:0] torque_in, // estimated torque
   output logic                   run_rev    // run direction
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div_r;
   initial
   begin
      div_r = 2'h0;
      freq_in = 16'sh0000;
      torque_in = 16'sh0000;
      run_rev = 1'b0;
   end
   // a slow stage moves its outputs only now and then
   always @(posedge clk)
   begin
      div_r <= div_r + 2'h1;
      if (!slow || div_r == 2'h0)
      begin
         freq_in <= freq_cmd;
         torque_in <= trq_cmd;
         run_rev <= rev_cmd;
      end
   end
endmodule // tls_stage_model

// >>> test/tb_torque_limit_select.sv
// self-checking bench for the torque limit selector
// assumes tls_top, its bound checker and the stage model
module tb_torque_limit_select;
   timeunit 1ns;
   timeprecision 1ps;
   logic               CLK, RESET_N, WR, RD, RUN_REV, RAMP_HOLD, LIMIT_ACT;
   logic               OPT1_FIT, OPT2_FIT, rev_cmd, slow, gate_asg, MOTOR2;
   logic [4:0]         ADDR, OUT_TERM;
   logic [15:0]        WDATA, RDATA;
   logic [7:0]         IN_TERM, OPT_LIMIT, TRQ_LIMIT;
   logic [9:0]         AUX_ADC;
   logic signed [15:0] FREQ_IN, TORQUE_IN, FREQ_OUT, f_cmd, t_cmd, fr, tq;
   logic [2:0]         meth, meth2, mode;
   logic [1:0]         cfg;
   logic [7:0]         lim [4];
   int                 failures, tests_run;
   tls_top dut (.CLK, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .IN_TERM, .AUX_ADC,
      .MOTOR2, .OPT1_FIT, .OPT2_FIT, .OPT_LIMIT, .FREQ_IN, .TORQUE_IN, .RUN_REV,
      .TRQ_LIMIT, .RAMP_HOLD, .LIMIT_ACT, .FREQ_OUT, .OUT_TERM);
   tls_stage_model stage (.clk(CLK), .slow, .freq_cmd(f_cmd), .trq_cmd(t_cmd), .rev_cmd,
      .freq_in(FREQ_IN), .torque_in(TORQUE_IN), .run_rev(RUN_REV));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      @(negedge CLK);
      chk("rdata", RDATA, e);
   endtask
   // vector method of the selected motor; code 05 only for motor one
   function automatic logic vec_ok();
      return MOTOR2 ? (meth2 == 3'h3 || meth2 == 3'h4) : (meth >= 3'h3 && meth <= 3'h5);
   endfunction
   // returns {limiting, applied limit}
   function automatic logic [8:0] exp_lim();
      logic [1:0]  q;
      logic [7:0]  l;
      logic [15:0] fa, ta;
      fa = f_cmd < 0 ? 16'(-f_cmd) : 16'(f_cmd);
      ta = t_cmd < 0 ? 16'(-t_cmd) : 16'(t_cmd);
      q = f_cmd < 0 ? (t_cmd < 0 ? 2'h2 : 2'h1) : (t_cmd < 0 ? 2'h3 : 2'h0);
      if (!vec_ok() || fa < 16'h012C || mode > 3'h4
          || (gate_asg && !IN_TERM[0]) || (mode == 3'h3 && !OPT1_FIT)
          || (mode == 3'h4 && !OPT2_FIT))
         return {1'b0, 8'hC8};
      case (mode)
         3'h0: l = lim[q];
         3'h1: l = lim[IN_TERM[7:6]];
         3'h2: l = 8'((32'(AUX_ADC) * 32'hC8) / 32'h3FF);
         default: l = OPT_LIMIT;
      endcase
      return {ta >= 16'(l), l};
   endfunction
   task automatic check_all();
      logic [8:0] e;
      logic       vec;
      e = exp_lim();
      vec = vec_ok();
      chk("limit", 16'(TRQ_LIMIT), 16'(e[7:0]));
      chk("active", 16'(LIMIT_ACT), 16'(e[8]));
      chk("term", 16'(OUT_TERM), 16'(e[8]));
      chk("hold", 16'(RAMP_HOLD), 16'(cfg[0] & vec & e[8]));
      chk("freq", FREQ_OUT, (cfg[1] && vec && f_cmd != 0 && (f_cmd < 0) != rev_cmd) ? 16'h0 : f_cmd);
   endtask
   task automatic step(input logic signed [15:0] f, t, input logic [7:0] term, input logic [9:0] adc);
      @(posedge CLK);
      f_cmd <= f;
      t_cmd <= t;
      IN_TERM <= term;
      AUX_ADC <= adc;
      repeat (20) @(posedge CLK);
      @(negedge CLK);
      check_all();
   endtask
   initial
   begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   initial
   begin
      repeat (20000) @(posedge CLK);
      failures++;
      end_of_test();
   end
   initial
   begin
      {RESET_N, WR, RD, OPT1_FIT, OPT2_FIT, rev_cmd, slow, gate_asg, MOTOR2} = '0;
      {ADDR, WDATA, IN_TERM, OPT_LIMIT, AUX_ADC, f_cmd, t_cmd} = '0;
      {meth, meth2, mode, cfg, failures, tests_run} = '0;
      lim = '{8'hB4, 8'hB4, 8'hB4, 8'hB4};
      void'($urandom(81));
      repeat (12) @(posedge CLK);
      RESET_N <= 1'b1;
      rd(tls_pkg::A_IN_FUNC, 16'h00FF);
      rd(5'h1F, 16'h0000);
      step(16'sh0BB8, 16'sh00C8, 8'h00, 10'h000);
      wr(tls_pkg::A_METHOD, 16'h0055);
      rd(tls_pkg::A_METHOD, 16'h0005);
      wr(tls_pkg::A_METHOD, 16'h0043);
      meth = 3'h3;
      meth2 = 3'h4;
      wr(tls_pkg::A_LIMIT1, 16'h00FF);
      rd(tls_pkg::A_LIMIT1, 16'h00B4);
      for (int i = 0; i < 4; i++)
      begin
         lim[i] = 8'($urandom_range(32'hB4));
         wr(tls_pkg::A_LIMIT1 + 5'(i), {8'h00, lim[i]});
      end
      wr(tls_pkg::A_CFG, 16'h0003);
      cfg = 2'h3;
      wr(tls_pkg::A_OUT_FUNC, {8'h00, tls_pkg::FN_ACTIVE});
      wr(tls_pkg::A_IN_FUNC + 5'h6, {8'h00, tls_pkg::FN_SW_A});
      wr(tls_pkg::A_IN_FUNC + 5'h7, {8'h00, tls_pkg::FN_SW_B});
      for (int q = 0; q < 4; q++)
      begin
         fr = 16'h012C + 16'($urandom_range(32'hBB8));
         tq = 16'($urandom_range(32'hFA));
         step((q == 1 || q == 2) ? -fr : fr, q > 1 ? -tq : tq, 8'h00, 10'h000);
      end
      step(16'sh012B, 16'sh00C8, 8'h00, 10'h000);
      step(-16'sh012C, 16'sh00C8, 8'h00, 10'h000);
      for (int m = 1; m < 6; m++)
      begin
         mode = 3'(m);
         wr(tls_pkg::A_MODE, 16'(m));
         for (int c = 0; c < 4; c++)
         begin
            @(posedge CLK);
            OPT1_FIT <= c[0];
            OPT2_FIT <= c[0];
            OPT_LIMIT <= 8'($urandom_range(32'hC8));
            step(16'sh0BB8, 16'sh0064, {2'(c), 6'h00}, c[1] ? 10'($urandom) : {10{c[0]}});
         end
      end
      wr(tls_pkg::A_IN_FUNC, {8'h00, tls_pkg::FN_GATE});
      gate_asg = 1'b1;
      mode = 3'h1;
      wr(tls_pkg::A_MODE, 16'h0001);
      step(16'sh0BB8, 16'sh00B4, 8'h40, 10'h000);
      step(16'sh0BB8, 16'sh00B4, 8'h41, 10'h000);
      @(posedge CLK);
      slow <= 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         mode = 3'($urandom_range(2));
         wr(tls_pkg::A_MODE, 16'(mode));
         rev_cmd <= 1'($urandom_range(1));
         fr = 16'($urandom_range(32'h1F40)) - 16'h0FA0;
         tq = 16'($urandom_range(32'h1F4)) - 16'h00FA;
         step(fr, tq, 8'($urandom), 10'($urandom));
      end
      wr(tls_pkg::A_METHOD, 16'h0002);
      meth = 3'h2;
      meth2 = 3'h0;
      step(-16'sh0BB8, 16'sh00C8, 8'h01, 10'h000);
      // motor two keeps its method 3 when 5 is offered for it
      wr(tls_pkg::A_METHOD, 16'h0035);
      wr(tls_pkg::A_METHOD, 16'h0052);
      meth2 = 3'h3;
      MOTOR2 <= 1'b1;
      step(-16'sh0BB8, 16'sh00C8, 8'h01, 10'h000);
      end_of_test();
   end
endmodule // tb_torque_limit_select
